// >>> verilog/clock_reset_unit.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "clk_rst_params.svh"
module clock_reset_unit
  import clk_rst_pkg::*;
#(
  parameter int TICK_PRESCALE = 16,
  parameter int WD_BASE_BITS  = 8
) (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  // register port
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // mode requests and analog status
  input  wire logic       wait_mode_in,
  input  wire logic       stop_mode_in,
  input  wire logic       clock_lost_in,
  input  wire logic       ref_edge_in,
  input  wire logic       ref_amp_ok_in,
  input  wire logic       pll_locked_in,
  input  wire logic       pll_tracking_in,
  input  wire logic       power_on_in,
  input  wire logic       low_voltage_in,
  // reset pin, open drain
  input  wire logic       rst_pin_n_in,
  output logic            rst_pin_out,
  output logic            rst_pin_oe_out,
  // clock gating and status
  output clk_gate_s       gate_out,
  output logic            tick_out,
  output logic            sys_reset_out
);
  // refuse sizes the counters cannot hold: tick limit is 16 bits, watchdog limit 32 bits
  if (TICK_PRESCALE < 1 || TICK_PRESCALE > 516 ||
      WD_BASE_BITS < 2 || WD_BASE_BITS > 16) begin : g_bad_params
    $error("clock_reset_unit: bad parameter");
  end

  logic [5:0] mult_reg;
  logic [3:0] refdiv_reg;
  logic       tick_flag_reg, power_on_flag_reg, low_voltage_flag_reg;
  logic       lock_change_flag_reg, self_clock_change_flag_reg;
  logic       lock_prev_reg;
  logic       self_clock_prev_reg;
  logic       tick_irq_enable_reg, lock_irq_enable_reg, self_clock_irq_enable_reg;
  clock_source_select_s    clock_source_select_reg;
  pll_control_s    pll_control_reg;
  logic [6:0] tick_rate_field_reg;
  logic       watchdog_window_mode_reg, stop_in_debug_select_reg;
  logic [2:0] watchdog_rate_field_reg;
  scm_state_e scm_reg;
  logic [15:0] qchk_reg;
  logic [7:0] rst_cnt_reg;
  logic       wd_armed_reg;
  logic       wd_timeout;
  logic       rst_req;
  logic       self_clock_status;
  logic       lock_bit, track_bit;
  logic       tick_run, wd_run;
  logic [7:0] rd_mux;

  // pin low from outside resets all but the supply flags and the stretch counter, so the pin counts as a reset source
  logic rst_n;
  assign rst_n = reset_n_in & rst_pin_n_in;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign self_clock_status = (scm_reg != MODE_NORMAL);
  // lock and track read zero in self-clock since the loop runs open
  assign lock_bit  = pll_locked_in & ~self_clock_status;
  assign track_bit = pll_tracking_in & ~self_clock_status;

  // multiplier and divider: frozen while pll_clock_select is set
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n) begin
      mult_reg   <= 6'h00;
      refdiv_reg <= 4'h0;
    end else if (wr_in && !clock_source_select_reg.pll_clock_select) begin
      if (hit(addr_in, `OFS_MULT))   mult_reg   <= wdata_in[5:0];
      if (hit(addr_in, `OFS_REFDIV)) refdiv_reg <= wdata_in[3:0];
    end
  end

  // control registers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n) begin
      tick_irq_enable_reg       <= 1'b0;
      lock_irq_enable_reg       <= 1'b0;
      self_clock_irq_enable_reg <= 1'b0;
      clock_source_select_reg                <= clock_source_select_s'(`RST_ZERO);
      pll_control_reg                <= pll_control_s'(`RST_PLL_CONTROL);
      tick_rate_field_reg       <= 7'h00;
      watchdog_window_mode_reg  <= 1'b0;
      stop_in_debug_select_reg  <= 1'b0;
      watchdog_rate_field_reg   <= 3'h0;
    end else if (wr_in) begin
      if (hit(addr_in, `OFS_IRQEN)) begin
        tick_irq_enable_reg       <= wdata_in[7];
        lock_irq_enable_reg       <= wdata_in[4];
        self_clock_irq_enable_reg <= wdata_in[1];
      end
      if (hit(addr_in, `OFS_CLOCK_SOURCE_SELECT)) begin
        clock_source_select_reg <= clock_source_select_s'(wdata_in);
        // pll cannot be chosen in self-clock or while unlocked
        clock_source_select_reg.pll_clock_select <= wdata_in[7] & lock_bit;
      end
      if (hit(addr_in, `OFS_PLL_CONTROL)) begin
        pll_control_reg         <= pll_control_s'(wdata_in);
        pll_control_reg.unused3 <= 1'b0;
      end
      if (hit(addr_in, `OFS_TICK)) tick_rate_field_reg <= wdata_in[6:0];
      if (hit(addr_in, `OFS_WDCTL)) begin
        watchdog_window_mode_reg <= wdata_in[7];
        stop_in_debug_select_reg <= wdata_in[6];
        watchdog_rate_field_reg  <= wdata_in[2:0];
      end
    end else if (self_clock_status) begin
      clock_source_select_reg.pll_clock_select <= 1'b0;
    end
  end

  // flags: hardware set wins over a write-one clear
  logic flag_wr;
  assign flag_wr = wr_in && hit(addr_in, `OFS_FLAGS);
  logic tick_event;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n) begin
      tick_flag_reg              <= 1'b0;
      lock_change_flag_reg       <= 1'b0;
      self_clock_change_flag_reg <= 1'b0;
      lock_prev_reg              <= 1'b0;
      self_clock_prev_reg        <= 1'b0;
    end else begin
      lock_prev_reg <= lock_bit;
      self_clock_prev_reg <= self_clock_status;
      tick_flag_reg <= tick_event | (tick_flag_reg & ~(flag_wr & wdata_in[7]));
      lock_change_flag_reg <= (lock_bit != lock_prev_reg) |
                              (lock_change_flag_reg & ~(flag_wr & wdata_in[4]));
      // status changes both ways, so entry and exit each raise the flag
      self_clock_change_flag_reg <= (self_clock_status != self_clock_prev_reg) |
                                    (self_clock_change_flag_reg & ~(flag_wr & wdata_in[1]));
    end
  end

  // power-on and low-voltage flags survive system reset, only power resets them
  always_ff @(posedge ref_clk_in) begin
    if (power_on_in) begin
      power_on_flag_reg    <= 1'b1;
      low_voltage_flag_reg <= 1'b0;
    end else begin
      if (low_voltage_in) low_voltage_flag_reg <= 1'b1;
      else if (flag_wr && wdata_in[5]) low_voltage_flag_reg <= 1'b0;
      if (flag_wr && wdata_in[6]) power_on_flag_reg <= 1'b0;
    end
  end

  // self-clock entry and quality check, counts reference edges
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n) begin
      scm_reg  <= MODE_NORMAL;
      qchk_reg <= 16'h0000;
    end else begin
      case (scm_reg)
        MODE_NORMAL: begin
          if (pll_control_reg.clock_monitor_enable && pll_control_reg.self_clock_enable &&
              clock_lost_in) begin
            scm_reg  <= MODE_CHECK;
            qchk_reg <= `QCHK_EDGES;
          end
        end
        MODE_CHECK: begin
          // leave only after enough good edges in a row
          if (!ref_amp_ok_in || clock_lost_in) qchk_reg <= `QCHK_EDGES;
          else if (ref_edge_in && qchk_reg != 16'h0000) qchk_reg <= qchk_reg - 16'h0001;
          if (qchk_reg == 16'h0000) scm_reg <= MODE_NORMAL;
        end
        default: scm_reg <= MODE_NORMAL;
      endcase
    end
  end

  // stop and wait gating of the periodic counters
  assign tick_run = (tick_rate_field_reg != 7'h00) &&
                    !(stop_mode_in && (!clock_source_select_reg.stop_kind_select ||
                      !pll_control_reg.tick_pseudo_stop_enable)) &&
                    !(wait_mode_in && clock_source_select_reg.tick_wait_off);
  assign wd_run   = (watchdog_rate_field_reg != 3'h0) &&
                    !(stop_mode_in && (!clock_source_select_reg.stop_kind_select ||
                      !pll_control_reg.watchdog_pseudo_stop_enable)) &&
                    !(wait_mode_in && clock_source_select_reg.watchdog_wait_off);

  // periodic tick: prescale times rate
  logic [15:0] tick_cnt_reg;
  logic [15:0] tick_lim;
  assign tick_lim = 16'(TICK_PRESCALE) * {9'h000, tick_rate_field_reg};
  assign tick_event = tick_run && (tick_cnt_reg >= tick_lim - 16'h0001);
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n) tick_cnt_reg <= 16'h0000;
    else if (tick_event) tick_cnt_reg <= 16'h0000;
    else if (tick_run) tick_cnt_reg <= tick_cnt_reg + 16'h0001;
  end
  assign tick_out = tick_flag_reg & tick_irq_enable_reg;

  // watchdog: 2^(base+2*rate) cycles, serviced by key pair, window mode
  logic [31:0] wd_cnt_reg;
  logic [31:0] wd_lim;
  logic        svc_wr;
  assign wd_lim = 32'h1 << (WD_BASE_BITS + 2 * int'(watchdog_rate_field_reg));
  assign svc_wr = wr_in && hit(addr_in, `OFS_WDSVC);
  logic early;
  assign early = watchdog_window_mode_reg && (wd_cnt_reg < (wd_lim - (wd_lim >> 2)));
  logic bad_svc;
  assign bad_svc = svc_wr && ((wdata_in != `WD_KEY1 && wdata_in != `WD_KEY2) || early);
  assign wd_timeout = (wd_run && wd_cnt_reg >= wd_lim - 32'h1) || bad_svc;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n) begin
      wd_cnt_reg   <= 32'h0;
      wd_armed_reg <= 1'b0;
    end else if (svc_wr && wdata_in == `WD_KEY1) begin
      wd_armed_reg <= 1'b1;
      if (wd_run) wd_cnt_reg <= wd_cnt_reg + 32'h1;
    end else if (svc_wr && wdata_in == `WD_KEY2 && wd_armed_reg) begin
      wd_armed_reg <= 1'b0;
      wd_cnt_reg   <= 32'h0;
    end else if (wd_run) begin
      wd_cnt_reg <= wd_cnt_reg + 32'h1;
    end
  end

  // reset sources and pin stretch
  assign rst_req = power_on_in | low_voltage_in | wd_timeout |
                   (clock_lost_in && pll_control_reg.clock_monitor_enable &&
                    !pll_control_reg.self_clock_enable);
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) rst_cnt_reg <= `RST_STRETCH;
    else if (rst_req) rst_cnt_reg <= `RST_STRETCH;
    else if (rst_cnt_reg != 8'h00) rst_cnt_reg <= rst_cnt_reg - 8'h01;
  end
  assign rst_pin_out    = 1'b0;
  assign rst_pin_oe_out = (rst_cnt_reg != 8'h00);
  assign sys_reset_out  = (rst_cnt_reg != 8'h00) | ~rst_n;

  // clock gating
  always_comb begin
    gate_out = '0;
    gate_out.osc_en      = !(stop_mode_in && !clock_source_select_reg.stop_kind_select);
    gate_out.sys_clk_en  = !stop_mode_in &&
                           !(wait_mode_in && clock_source_select_reg.system_clock_wait_off);
    gate_out.core_clk_en = !stop_mode_in &&
                           !(wait_mode_in && clock_source_select_reg.core_clock_wait_off);
    gate_out.pll_en      = (pll_control_reg.pll_power_on || self_clock_status) && !stop_mode_in &&
                           !(wait_mode_in && clock_source_select_reg.pll_wait_off);
    gate_out.from_pll    = clock_source_select_reg.pll_clock_select | self_clock_status;
    gate_out.pll_min_freq = self_clock_status;
  end

  // read mux, test registers and service read zero
  always_comb begin
    rd_mux = 8'h00;
    case (addr_in)
      `OFS_MULT:   rd_mux = {2'b00, mult_reg};
      `OFS_REFDIV: rd_mux = {4'h0, refdiv_reg};
      `OFS_FLAGS:  rd_mux = {tick_flag_reg, power_on_flag_reg, low_voltage_flag_reg,
                             lock_change_flag_reg, lock_bit, track_bit,
                             self_clock_change_flag_reg, self_clock_status};
      `OFS_IRQEN:  rd_mux = {tick_irq_enable_reg, 2'b00, lock_irq_enable_reg, 2'b00,
                             self_clock_irq_enable_reg, 1'b0};
      `OFS_CLOCK_SOURCE_SELECT: rd_mux = clock_source_select_reg;
      `OFS_PLL_CONTROL: rd_mux = pll_control_reg;
      `OFS_TICK:   rd_mux = {1'b0, tick_rate_field_reg};
      `OFS_WDCTL:  rd_mux = {watchdog_window_mode_reg, stop_in_debug_select_reg, 3'b000,
                             watchdog_rate_field_reg};
      default:     rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n) rdata_out <= 8'h00;
    else if (rd_in) rdata_out <= rd_mux;
    else rdata_out <= 8'h00;
  end

  // stop modes: full stop freezes everything, pseudo-stop keeps the oscillator
  AST_FULL_STOP_OSC: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    stop_mode_in && !clock_source_select_reg.stop_kind_select |-> !gate_out.osc_en && !tick_run && !wd_run)
    else $error("full stop leaves clocks");

  AST_FULL_STOP_GATES: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    stop_mode_in && !clock_source_select_reg.stop_kind_select |->
      !gate_out.sys_clk_en && !gate_out.core_clk_en)
    else $error("full stop leaves system clocks");

  AST_PSTOP_OSC: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    stop_mode_in && clock_source_select_reg.stop_kind_select |-> gate_out.osc_en && !gate_out.sys_clk_en)
    else $error("pseudo stop gating wrong");

  AST_PSTOP_TICK: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    stop_mode_in && !pll_control_reg.tick_pseudo_stop_enable |=> $stable(tick_cnt_reg))
    else $error("tick ran in stop");

  // wait mode: the system and core gates each follow their own clock-select bit
  AST_WAIT_SYS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    wait_mode_in && clock_source_select_reg.system_clock_wait_off |-> !gate_out.sys_clk_en)
    else $error("system clock ran in wait");

  AST_WAIT_CORE: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    wait_mode_in && clock_source_select_reg.core_clock_wait_off |-> !gate_out.core_clk_en)
    else $error("core clock ran in wait");

  // self-clock entry, quality check and exit
  AST_SCM_ENTRY: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    $rose(self_clock_status) |-> $past(clock_lost_in) && $past(pll_control_reg.self_clock_enable))
    else $error("bad self-clock entry");

  AST_SCM_CHECK: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    $rose(self_clock_status) |-> qchk_reg == `QCHK_EDGES)
    else $error("check not started");

  AST_SCM_EXIT: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    $fell(self_clock_status) |-> $past(qchk_reg) == 16'h0000)
    else $error("left self-clock early");

  AST_SCM_CLOCK: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    self_clock_status |-> gate_out.from_pll && gate_out.pll_min_freq)
    else $error("self-clock source wrong");

  // lock and track must read zero while the loop runs open
  AST_SCM_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    rd_in && addr_in == `OFS_FLAGS && self_clock_status |=>
      rdata_out[3:2] == 2'b00 && rdata_out[0])
    else $error("flags wrong in self-clock");

  // reset pin: the stretch holds the pin for its full count
  AST_RST_PIN: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    rst_req |=> rst_pin_oe_out [*8])
    else $error("reset pin not driven");

  AST_STRETCH_END: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    $fell(rst_pin_oe_out) |-> $past(rst_cnt_reg) == 8'h01)
    else $error("reset pin released early");

  AST_PIN_RESET: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !rst_pin_n_in |-> sys_reset_out)
    else $error("pin low without system reset");

  // the watchdog alarm drops rst_n through the pin, so only the bench reset may disable
  AST_WD_RESET: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wd_timeout |=> sys_reset_out)
    else $error("watchdog time-out ignored");

  // register behaviour
  AST_MULT_FROZEN: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    wr_in && addr_in == `OFS_MULT && clock_source_select_reg.pll_clock_select |=> $stable(mult_reg))
    else $error("multiplier changed while pll selected");

  AST_IRQ_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    rd_in && addr_in == `OFS_IRQEN |=> (rdata_out & 8'h6d) == 8'h00)
    else $error("unimplemented enable bit read one");

  AST_SVC_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    rd_in && addr_in == `OFS_WDSVC |=> rdata_out == 8'h00)
    else $error("service register read nonzero");

  AST_TEST_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    rd_in && (addr_in == `OFS_TFLG || addr_in == `OFS_FORBY || addr_in == `OFS_TCTL) |=>
      rdata_out == 8'h00)
    else $error("test register read nonzero");

  AST_TICK_FLAG: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    tick_event |=> tick_flag_reg)
    else $error("tick event lost");

  // supply flags live outside system reset, so no disable here
  AST_POR_FLAG: assert property (@(posedge ref_clk_in)
    power_on_in |=> power_on_flag_reg)
    else $error("power-on flag not set");

  AST_LV_FLAG: assert property (@(posedge ref_clk_in)
    low_voltage_in && !power_on_in |=> low_voltage_flag_reg)
    else $error("low-voltage flag not set");

  AST_LOCK_FLAG: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    lock_bit != lock_prev_reg |=> lock_change_flag_reg)
    else $error("lock change lost");
endmodule : clock_reset_unit

// >>> common/clk_rst_params.svh
`ifndef CLK_RST_PARAMS_SVH
`define CLK_RST_PARAMS_SVH
`define OFS_MULT      4'h0
`define OFS_REFDIV    4'h1
`define OFS_TFLG      4'h2
`define OFS_FLAGS     4'h3
`define OFS_IRQEN     4'h4
`define OFS_CLOCK_SOURCE_SELECT    4'h5
`define OFS_PLL_CONTROL    4'h6
`define OFS_TICK      4'h7
`define OFS_WDCTL     4'h8
`define OFS_FORBY     4'h9
`define OFS_TCTL      4'ha
`define OFS_WDSVC     4'hb
`define RST_PLL_CONTROL    8'hf1
`define RST_ZERO      8'h00
`define WD_KEY1       8'h55
`define WD_KEY2       8'haa
`define QCHK_EDGES    16'd50
`define RST_STRETCH   8'd64
`endif

// >>> common/clk_rst_pkg.sv
package clk_rst_pkg;
  typedef struct packed {
    logic       pll_clock_select;
    logic       stop_kind_select;
    logic       system_clock_wait_off;
    logic       oscillator_wait_reduce;
    logic       pll_wait_off;
    logic       core_clock_wait_off;
    logic       tick_wait_off;
    logic       watchdog_wait_off;
  } clock_source_select_s;
  typedef struct packed {
    logic       clock_monitor_enable;
    logic       pll_power_on;
    logic       auto_bandwidth;
    logic       acquisition_select;
    logic       unused3;
    logic       tick_pseudo_stop_enable;
    logic       watchdog_pseudo_stop_enable;
    logic       self_clock_enable;
  } pll_control_s;
  typedef struct packed {
    logic       sys_clk_en;
    logic       core_clk_en;
    logic       osc_en;
    logic       pll_en;
    logic       from_pll;
    logic       pll_min_freq;
  } clk_gate_s;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_CHECK  = 3'b010,
    MODE_RESET  = 3'b100
  } scm_state_e;
endpackage : clk_rst_pkg

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import clk_rst_pkg::*;
  // clock, reset and register port
  logic            ref_clk_in;
  logic            reset_n_in;
  logic      [3:0] addr_in;
  logic      [7:0] wdata_in;
  logic            wr_in;
  logic            rd_in;
  logic      [7:0] rdata_out;
  // mode requests and analog status
  logic            wait_mode_in;
  logic            stop_mode_in;
  logic            clock_lost_in;
  logic            ref_edge_in;
  logic            ref_amp_ok_in;
  logic            pll_locked_in;
  logic            pll_tracking_in;
  logic            power_on_in;
  logic            low_voltage_in;
  // reset pin and outputs
  logic            ext_rst_n;
  wire             rst_line_n;
  logic            rst_pin_out;
  logic            rst_pin_oe_out;
  clk_gate_s       gate_out;
  logic            tick_out;
  logic            sys_reset_out;
  int              failures;
  int              n_compared;
  logic      [7:0] rst_exp [12] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00,
                                    8'hf1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic      [7:0] ff_exp  [12] = '{8'h3f, 8'h0f, 8'h00, 8'h00, 8'h92, 8'h7f,
                                    8'hf7, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00};

  // open-drain pin with pull-up: low when either side pulls it
  assign rst_line_n = ext_rst_n & (rst_pin_oe_out ? rst_pin_out : 1'b1);

  clock_reset_unit #(.TICK_PRESCALE(16), .WD_BASE_BITS(2)) dut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .wait_mode_in(wait_mode_in), .stop_mode_in(stop_mode_in),
    .clock_lost_in(clock_lost_in), .ref_edge_in(ref_edge_in),
    .ref_amp_ok_in(ref_amp_ok_in), .pll_locked_in(pll_locked_in),
    .pll_tracking_in(pll_tracking_in), .power_on_in(power_on_in),
    .low_voltage_in(low_voltage_in), .rst_pin_n_in(rst_line_n),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_out(rst_pin_oe_out),
    .gate_out(gate_out), .tick_out(tick_out), .sys_reset_out(sys_reset_out));

  // 10 mhz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic e, input string m);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, m, g, e);
    end
  endtask : chk1

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] e,
                    input string m);
    @(posedge ref_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    chk8(rdata_out & mask, e, m);
  endtask : rd

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : cycles

  // bounded wait for the reset stretch to end
  task automatic settle;
    for (int i = 0; i < 400 && sys_reset_out !== 1'b0; i++) cycles(1);
    chk1(sys_reset_out, 1'b0, "reset stretch never ended");
  endtask : settle

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk_in);
      ref_edge_in <= 1'b1;
      @(posedge ref_clk_in);
      ref_edge_in <= 1'b0;
    end
  endtask : pulses

  // gate enables compared as {sys, core, osc} under a mask
  task automatic gate_case(input logic [7:0] sel, input logic w, input logic s,
                           input logic [2:0] mask, input logic [2:0] e, input string m);
    wr(4'h5, sel);
    wait_mode_in <= w;
    stop_mode_in <= s;
    cycles(3);
    chk8({5'h00, {gate_out.sys_clk_en, gate_out.core_clk_en, gate_out.osc_en} & mask},
         {5'h00, e}, m);
    wait_mode_in <= 1'b0;
    stop_mode_in <= 1'b0;
  endtask : gate_case

  // trigger one reset source, then see the pin driven unless the pin itself was pulled, and registers restored
  task automatic reset_case(input logic [7:0] pc, input int src, input logic [7:0] fmask,
                            input logic [7:0] fexp, input string m);
    wr(4'h6, pc);
    wr(4'h0, 8'h15);
    @(posedge ref_clk_in);
    case (src)
      0: power_on_in <= 1'b1;
      1: low_voltage_in <= 1'b1;
      2: ext_rst_n <= 1'b0;
      3: clock_lost_in <= 1'b1;
      default: ;
    endcase
    @(posedge ref_clk_in);
    power_on_in <= 1'b0;
    low_voltage_in <= 1'b0;
    ext_rst_n <= 1'b1;
    // the pin alone resets without a stretch, else its own low would retrigger it
    for (int i = 0; i < 80 && rst_pin_oe_out !== (src != 2); i++) cycles(1);
    chk1(rst_pin_oe_out, src != 2, m);
    clock_lost_in <= 1'b0;
    settle();
    rd(4'h0, 8'hff, 8'h00, m);
    rd(4'h6, 8'hff, 8'hf1, m);
    rd(4'h3, fmask, fexp, m);
  endtask : reset_case

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog: the whole sequence needs under a thousand cycles
  initial begin
    #2_000_000;
    failures++;
    tally_and_finish();
  end

  initial begin
    {reset_n_in, wr_in, rd_in, wait_mode_in, stop_mode_in, clock_lost_in} = '0;
    {ref_edge_in, ref_amp_ok_in, pll_locked_in, pll_tracking_in} = '0;
    {low_voltage_in, addr_in, wdata_in} = '0;
    power_on_in = 1'b1; // supply comes up while reset is held, so the flags start known
    ext_rst_n = 1'b1;
    failures = 0;
    n_compared = 0;
    repeat (3) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    power_on_in <= 1'b0;
    settle();
    // reset values, then masks of implemented bits
    for (int i = 0; i < 12; i++) rd(i[3:0], 8'hff, rst_exp[i], "reset value");
    rd(4'hc, 8'hff, 8'h00, "unmapped read");
    for (int i = 0; i < 11; i++) begin
      if (i != 3 && i != 8) begin
        wr(i[3:0], 8'hff);
        rd(i[3:0], 8'hff, ff_exp[i], "bit mask");
      end
    end
    wr(4'h7, 8'h00);
    wr(4'h3, 8'h40);
    wr(4'hb, 8'h55);
    wr(4'hb, 8'haa);
    rd(4'hb, 8'hff, 8'h00, "service reads zero");
    // lock change, refused writes while pll selected, write-one clear
    pll_locked_in <= 1'b1;
    cycles(3);
    rd(4'h3, 8'hff, 8'h18, "lock flags");
    wr(4'h5, 8'h80);
    rd(4'h5, 8'hff, 8'h80, "pll select when locked");
    wr(4'h0, 8'h05);
    rd(4'h0, 8'hff, 8'h3f, "multiplier locked while pll selected");
    wr(4'h3, 8'h00);
    rd(4'h3, 8'hff, 8'h18, "write zero keeps flag");
    wr(4'h3, 8'h10);
    rd(4'h3, 8'hff, 8'h08, "write one clears flag");
    wr(4'h5, 8'h00);
    // self-clock entry and quality-checked exit
    clock_lost_in <= 1'b1;
    cycles(4);
    chk1(gate_out.pll_min_freq, 1'b1, "self clock minimum");
    rd(4'h3, 8'h03, 8'h03, "self clock status");
    clock_lost_in <= 1'b0;
    ref_amp_ok_in <= 1'b1;
    pulses(40);
    rd(4'h3, 8'h01, 8'h01, "self clock left early");
    pulses(20);
    cycles(4);
    rd(4'h3, 8'h01, 8'h00, "self clock not left");
    chk1(gate_out.pll_min_freq, 1'b0, "minimum after exit");
    // wait and stop gating
    gate_case(8'h24, 1'b0, 1'b0, 3'b111, 3'b111, "run gating");
    gate_case(8'h20, 1'b1, 1'b0, 3'b100, 3'b000, "wait sys off");
    gate_case(8'h04, 1'b1, 1'b0, 3'b110, 3'b100, "wait core off");
    gate_case(8'h00, 1'b0, 1'b1, 3'b111, 3'b000, "full stop");
    gate_case(8'h40, 1'b0, 1'b1, 3'b011, 3'b001, "pseudo stop");
    // periodic tick: frozen in pseudo-stop without its enable, then running
    wr(4'h5, 8'h40);
    wr(4'h6, 8'hf3);
    wr(4'h4, 8'h80);
    stop_mode_in <= 1'b1;
    wr(4'h7, 8'h01);
    cycles(40);
    chk1(tick_out, 1'b0, "tick ran in pseudo stop");
    stop_mode_in <= 1'b0;
    for (int i = 0; i < 60 && tick_out !== 1'b1; i++) cycles(1);
    chk1(tick_out, 1'b1, "tick raised");
    rd(4'h3, 8'h80, 8'h80, "tick flag");
    wr(4'h7, 8'h00);
    wr(4'h3, 8'h80);
    cycles(2);
    chk1(tick_out, 1'b0, "tick cleared");
    // reset sources and the open-drain pin
    reset_case(8'h01, 0, 8'h40, 8'h40, "power-on reset");
    wr(4'h3, 8'h60);
    reset_case(8'h01, 1, 8'h60, 8'h20, "low-voltage reset");
    reset_case(8'h01, 2, 8'h00, 8'h00, "pin reset");
    reset_case(8'h80, 3, 8'h00, 8'h00, "clock loss reset");
    wr(4'h8, 8'hf9);
    rd(4'h8, 8'hff, 8'hc1, "watchdog control");
    reset_case(8'h01, 4, 8'h00, 8'h00, "watchdog reset");
    tally_and_finish();
  end
endmodule : tb_top
